// ---- mem_front_map.svh ----
// Offsets, field positions, reset values, clock period and delay times of the memory front end
`ifndef MEM_FRONT_MAP_SVH
`define MEM_FRONT_MAP_SVH
`define OFS_PAGE 8'hE0
`define OFS_SPACE_MAP 8'hC2
`define OFS_PMODE0 8'hB0
`define OFS_PMODE2 8'hB4
`define OFS_IDENT0 8'hF0
`define OFS_IDENT1 8'hF1
`define UNLOCK1_ADDR 12'hAAA
`define UNLOCK1_DATA 8'hAA
`define UNLOCK2_ADDR 12'h554
`define UNLOCK2_DATA 8'h55
`define SPACE_MAP_INIT 8'h0C
`define FAST_BIT 3
`define MAP_SRAM_PROG 0
`define MAP_SEC_PROG 1
`define MAP_PRI_PROG 2
`define MAP_SEC_DATA 3
`define MAP_PRI_DATA 4
`define CLK_PERIOD_PS 5000
`define RECOVER_NS 25000
`define STANDBY_NS 70
`endif

// ---- mem_front_pkg.sv ----
// Types shared by the memory front end
package mem_front_pkg;
  typedef enum logic [1:0] {OP_NONE, OP_PROGRAM, OP_BULK, OP_SECTOR} flash_op_t;
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic fetch;
    logic cfg;
  } host_bus_t;
  typedef struct packed {
    logic sram;
    logic io;
    logic [3:0] secondary;
    logic [7:0] primary;
  } mem_sel_t;
endpackage

// ---- mem_front.sv ----
// Memory select, page register, flash reset control and logic-array input bus
`timescale 1ns/1ps
`default_nettype none
`include "mem_front_map.svh"
module mem_front #(
  parameter int RECOVER_CYCLES = `RECOVER_NS * 1000 / `CLK_PERIOD_PS,
  parameter logic [7:0] IDENT0_VALUE = 8'h5A,
  parameter logic [7:0] IDENT1_VALUE = 8'hA5,
  parameter logic [7:0] RESET_CODE = 8'hF0
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire mem_front_pkg::host_bus_t BUS,
  input wire logic [23:0] PRIM_TERMS,
  input wire logic [11:0] SEC_TERMS,
  input wire logic [2:0] SRAM_TERMS,
  input wire logic IO_SEL,
  input wire mem_front_pkg::flash_op_t FLASH_OP,
  input wire logic FLASH_LEFT_READ,
  input wire logic SEQ_TIMEOUT,
  input wire logic SEQ_BAD_BIT,
  input wire logic RESET_PIN_N,
  input wire logic WIDE_ADDR,
  input wire logic POWER_DOWN_IN,
  input wire logic [35:0] PORT_IN,
  input wire logic [15:0] MC_FB,
  input wire logic [1:0] CTRL_AUX,
  output mem_front_pkg::mem_sel_t SEL_OUT,
  output logic [7:0] CFG_DOUT,
  output logic [7:0] PAGE_OUT,
  output logic READ_MODE,
  output logic ERROR_FLAG,
  output logic ABORT_SECTOR,
  output logic ABORT_ALL,
  output logic [81:0] LA_BUS,
  output logic [1:0] LA_AUX,
  output logic LA_STANDBY
);
  import mem_front_pkg::*;

  localparam int STANDBY_CYCLES = `STANDBY_NS * 1000 / `CLK_PERIOD_PS;
  localparam int CW = 16;

  // Counter widths cannot serve counts outside these ranges
  if (RECOVER_CYCLES < 1 || RECOVER_CYCLES >= (1 << CW) || STANDBY_CYCLES < 1
      || STANDBY_CYCLES > 32) begin : g_bad_param
    $error("Timing counts out of range");
  end

  // ==========================================================
  // Select priority and space mapping
  logic [7:0] space_map;
  logic [7:0] pmode0;
  logic [4:0] pmode2;
  wire [7:0] prim_raw;
  wire [3:0] sec_raw;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_prim
      assign prim_raw[g] = |PRIM_TERMS[g*3 +: 3];
    end
    for (g = 0; g < 4; g++) begin : g_sec
      assign sec_raw[g] = |SEC_TERMS[g*3 +: 3];
    end
  endgenerate
  wire sram_raw = |SRAM_TERMS;
  wire prog = BUS.fetch;
  wire data = BUS.rd | BUS.wr;
  wire high_raw = sram_raw | IO_SEL;
  wire sram_ok = sram_raw & (data | (prog & space_map[`MAP_SRAM_PROG]));
  wire io_ok = IO_SEL & data;
  wire sec_sp = (prog & space_map[`MAP_SEC_PROG]) | (data & space_map[`MAP_SEC_DATA]);
  wire pri_sp = (prog & space_map[`MAP_PRI_PROG]) | (data & space_map[`MAP_PRI_DATA]);
  wire [3:0] sec_ok = sec_raw & {4{sec_sp & ~high_raw}};
  wire [7:0] pri_ok = prim_raw & {8{pri_sp & ~high_raw & ~(|sec_raw)}};
  mem_sel_t next_sel;
  assign next_sel = '{sram: sram_ok, io: io_ok, secondary: sec_ok, primary: pri_ok};
  wire flash_hit = (|sec_ok) | (|pri_ok);

  // ==========================================================
  // Configuration register space
  wire cfg_wr = BUS.cfg & BUS.wr;
  wire [7:0] ofs = BUS.addr[7:0];
  wire [7:0] next_dout =
    (ofs == `OFS_PAGE) ? PAGE_OUT :
    (ofs == `OFS_SPACE_MAP) ? space_map :
    (ofs == `OFS_PMODE0) ? pmode0 :
    (ofs == `OFS_PMODE2) ? {3'h0, pmode2} :
    (ofs == `OFS_IDENT0) ? IDENT0_VALUE :
    (ofs == `OFS_IDENT1) ? IDENT1_VALUE : 8'h00;

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      PAGE_OUT <= 8'h00;
      space_map <= `SPACE_MAP_INIT;
      pmode0 <= 8'h00;
      pmode2 <= 5'h00;
      CFG_DOUT <= 8'h00;
      SEL_OUT <= '0;
    end else begin
      SEL_OUT <= next_sel;
      if (BUS.cfg && BUS.rd) begin
        CFG_DOUT <= next_dout;
      end
      if (cfg_wr && ofs == `OFS_PAGE) begin
        PAGE_OUT <= BUS.wdata;
      end
      if (cfg_wr && ofs == `OFS_SPACE_MAP) begin
        space_map <= BUS.wdata;
      end
      if (cfg_wr && ofs == `OFS_PMODE0) begin
        pmode0 <= BUS.wdata;
      end
      if (cfg_wr && ofs == `OFS_PMODE2) begin
        pmode2 <= BUS.wdata[4:0];
      end
    end
  end

  // ==========================================================
  // Reset pin filter
  logic pin_s1;
  logic pin_s2;
  logic pin_s3;
  logic pin_lvl;
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_s3 <= 1'b1;
      pin_lvl <= 1'b1;
    end else begin
      pin_s1 <= RESET_PIN_N;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_lvl <= pin_s3;
      end
    end
  end
  wire pin_fall = pin_lvl & (pin_s2 == pin_s3) & ~pin_s3;

  // ==========================================================
  // Flash reset command and recovery
  typedef enum logic [1:0] {UL_IDLE, UL_ONE, UL_TWO} unlock_t;
  typedef enum logic [1:0] {MD_READ, MD_OTHER, MD_RECOVER} mode_t;
  unlock_t unlock;
  unlock_t next_unlock;
  mode_t mode;
  mode_t next_mode;
  logic [CW-1:0] rec_cnt;
  logic [CW-1:0] next_cnt;
  logic err;
  wire flash_wr = BUS.wr & ~BUS.cfg & flash_hit;
  wire is_reset = flash_wr & (BUS.wdata == RESET_CODE);
  wire busy_op = (FLASH_OP == OP_PROGRAM) | (FLASH_OP == OP_BULK);
  wire sector_op = FLASH_OP == OP_SECTOR;
  wire op_run = FLASH_OP != OP_NONE;
  wire cmd_taken = is_reset & ~busy_op;
  wire cmd_abort = cmd_taken & sector_op;
  wire [CW-1:0] rec_load = CW'(RECOVER_CYCLES - 1);

  always_comb begin
    next_unlock = UL_IDLE;
    unique case (unlock)
      UL_IDLE: next_unlock = (flash_wr && BUS.addr[11:0] == `UNLOCK1_ADDR
                              && BUS.wdata == `UNLOCK1_DATA) ? UL_ONE : UL_IDLE;
      UL_ONE: next_unlock = (flash_wr && BUS.addr[11:0] == `UNLOCK2_ADDR
                             && BUS.wdata == `UNLOCK2_DATA) ? UL_TWO : UL_ONE;
      UL_TWO: next_unlock = UL_TWO;
      default: next_unlock = UL_IDLE;
    endcase
    if (flash_wr && (unlock == UL_TWO || (unlock == UL_ONE
        && next_unlock != UL_TWO))) begin
      next_unlock = UL_IDLE;
    end
  end

  always_comb begin
    next_mode = mode;
    next_cnt = rec_cnt;
    if (pin_fall) begin
      next_mode = (op_run || err) ? MD_RECOVER : MD_READ;
      next_cnt = rec_load;
    end else if (mode == MD_RECOVER) begin
      if (rec_cnt == '0) begin
        next_mode = MD_READ;
      end else begin
        next_cnt = rec_cnt - 1'b1;
      end
    end else if (cmd_taken) begin
      next_mode = (sector_op || err) ? MD_RECOVER : MD_READ;
      next_cnt = rec_load;
    end else if (op_run || FLASH_LEFT_READ) begin
      next_mode = MD_OTHER;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      unlock <= UL_IDLE;
      mode <= MD_READ;
      rec_cnt <= '0;
      err <= 1'b0;
      READ_MODE <= 1'b1;
      ERROR_FLAG <= 1'b0;
      ABORT_SECTOR <= 1'b0;
      ABORT_ALL <= 1'b0;
    end else begin
      unlock <= next_unlock;
      mode <= next_mode;
      rec_cnt <= next_cnt;
      if (SEQ_TIMEOUT || SEQ_BAD_BIT) begin
        err <= 1'b1;
      end else if (mode == MD_RECOVER && next_mode == MD_READ) begin
        err <= 1'b0;
      end
      ERROR_FLAG <= SEQ_TIMEOUT | SEQ_BAD_BIT | (err & ~(mode == MD_RECOVER
                    && next_mode == MD_READ));
      READ_MODE <= next_mode == MD_READ;
      ABORT_SECTOR <= cmd_abort & ~pin_fall;
      ABORT_ALL <= pin_fall;
    end
  end

  // ==========================================================
  // Logic-array input bus and standby
  wire [15:0] la_addr = WIDE_ADDR ? BUS.addr[19:4] : BUS.addr[15:0];
  wire [4:0] ctrl_in = {CTRL_AUX, BUS.fetch, BUS.rd, BUS.wr};
  wire [4:0] ctrl_g = ctrl_in & ~pmode2;
  wire ready_busy = op_run | (mode == MD_RECOVER);
  wire [81:0] next_la = {la_addr, ctrl_g[2:0], ~RESETN, POWER_DOWN_IN,
                         PORT_IN, PAGE_OUT, MC_FB, ready_busy};
  logic [4:0] idle_cnt;
  wire la_same = next_la == LA_BUS;
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      // Arrays see the reset input while it is held
      LA_BUS <= {19'h0, 1'b1, 62'h0};
      LA_AUX <= 2'h0;
      idle_cnt <= 5'h00;
      LA_STANDBY <= 1'b0;
    end else begin
      LA_BUS <= next_la;
      LA_AUX <= ctrl_g[4:3];
      idle_cnt <= !la_same ? 5'h00 : (idle_cnt == 5'h1F) ? idle_cnt : idle_cnt + 5'h01;
      LA_STANDBY <= ~pmode0[`FAST_BIT] & la_same
                    & (idle_cnt >= 5'(STANDBY_CYCLES - 1));
    end
  end

  // ==========================================================
  // Checks
  property p_sram_prio;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (sram_raw && data) |=> SEL_OUT.sram && SEL_OUT.primary == 8'h00 && SEL_OUT.secondary == 4'h0;
  endproperty
  a_sram_prio: assert property (p_sram_prio) else $error("SRAM lost priority");
  property p_sec_prio;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (!high_raw && |sec_raw && sec_sp) |=> SEL_OUT.primary == 8'h00 && |SEL_OUT.secondary;
  endproperty
  a_sec_prio: assert property (p_sec_prio) else $error("secondary lost priority");
  property p_sram_gate;
    @(posedge CLK_SYS) disable iff (!RESETN)
    !sram_raw |=> !SEL_OUT.sram;
  endproperty
  a_sram_gate: assert property (p_sram_gate) else $error("SRAM answered unselected");
  property p_map_sep;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (space_map == 8'h0C && BUS.rd && !BUS.fetch && !BUS.wr) |=> SEL_OUT.primary == 8'h00;
  endproperty
  a_map_sep: assert property (p_map_sep) else $error("primary in data space");
  property p_page_wr;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (cfg_wr && ofs == 8'hE0) |=> PAGE_OUT == $past(BUS.wdata)
      ##1 LA_BUS[24:17] == $past(PAGE_OUT);
  endproperty
  a_page_wr: assert property (p_page_wr) else $error("page write failed");
  property p_ignore;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (is_reset && busy_op && !pin_fall) |=> !ABORT_SECTOR && mode != MD_RECOVER;
  endproperty
  a_ignore: assert property (p_ignore) else $error("reset not ignored");
  property p_quick;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (cmd_taken && !sector_op && !err && !pin_fall && mode != MD_RECOVER) |=> READ_MODE;
  endproperty
  a_quick: assert property (p_quick) else $error("reset not immediate");
  property p_abort;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (cmd_abort && !pin_fall && mode != MD_RECOVER) |=> ABORT_SECTOR && !READ_MODE
      && rec_cnt == rec_load;
  endproperty
  a_abort: assert property (p_abort) else $error("sector erase not aborted");
  property p_pin;
    @(posedge CLK_SYS) disable iff (!RESETN)
    pin_fall |=> ABORT_ALL && (READ_MODE || rec_cnt == rec_load);
  endproperty
  a_pin: assert property (p_pin) else $error("reset pin not honoured");
  property p_fast;
    @(posedge CLK_SYS) disable iff (!RESETN)
    pmode0[3] |=> !LA_STANDBY;
  endproperty
  a_fast: assert property (p_fast) else $error("standby in fast mode");
  c_recover: cover property (@(posedge CLK_SYS) disable iff (!RESETN)
    mode == MD_RECOVER ##1 mode == MD_READ);
  c_unlocked: cover property (@(posedge CLK_SYS) disable iff (!RESETN)
    unlock == UL_TWO && cmd_taken);
  c_standby: cover property (@(posedge CLK_SYS) disable iff (!RESETN) LA_STANDBY);
endmodule
`default_nettype wire

// ---- host_model.sv ----
// Host bus master model that drives the memory front end
`timescale 1ns/1ps
`default_nettype none
`include "mem_front_map.svh"
module host_model (
  input wire logic clk,
  input wire logic [7:0] din,
  output var mem_front_pkg::host_bus_t bus,
  output logic pin_n,
  output logic [7:0] rdata
);
  import mem_front_pkg::*;
  initial begin
    bus = '0;
    pin_n = 1'b1;
    rdata = '0;
  end
  // One access: s is {wr, rd, fetch, cfg}; the idle cycle after it drives inverted address and data with all strobes low
  task automatic acc(input logic [19:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk);
    bus <= {a, d, s};
    @(posedge clk);
    bus <= {~a, ~d, 4'h0};
    #1;
    rdata = din;
  endtask
  task automatic flash_reset(input logic [19:0] a, input logic [7:0] c, input bit unlock);
    if (unlock) begin
      acc({8'h00, `UNLOCK1_ADDR}, `UNLOCK1_DATA, 4'h8);
      acc({8'h00, `UNLOCK2_ADDR}, `UNLOCK2_DATA, 4'h8);
    end
    acc(a, c, 4'h8);
  endtask
  task automatic pin_pulse(input int n);
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (n) @(posedge clk);
    pin_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- memory_select_page_and_flash_reset_test.sv ----
// Self-checking bench for the memory front end
`timescale 1ns/1ps
`default_nettype none
`include "mem_front_map.svh"
module memory_select_page_and_flash_reset_test;
  import mem_front_pkg::*;
  localparam int RC = 20;
  localparam logic [7:0] RCODE = 8'hF0;
  // Arbitrary identification values
  localparam logic [7:0] ID_A = 8'h3C;
  localparam logic [7:0] ID_B = 8'hC3;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  host_bus_t bus;
  logic pin_n;
  logic [23:0] prim = '0;
  logic [11:0] sec = '0;
  logic [2:0] sram = '0;
  logic io = 1'b0;
  flash_op_t op = OP_NONE;
  logic left = 1'b0;
  logic tmo = 1'b0;
  logic bad = 1'b0;
  logic wide = 1'b0;
  logic power_down_input = 1'b0;
  logic [35:0] port_pins = '0;
  logic [15:0] mcfb = '0;
  mem_sel_t sel;
  logic [7:0] cfg_dout;
  logic [7:0] page;
  logic rmode, eflag, abs, aba, sb;
  logic [81:0] la;
  logic [1:0] la_aux;
  int compares = 0;
  int n_mismatch = 0;
  int n_abort = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (aba === 1'b1) n_abort <= n_abort + 1;
  host_model h (.clk(clk), .din(cfg_dout), .bus(bus), .pin_n(pin_n), .rdata());
  mem_front #(.RECOVER_CYCLES(RC), .IDENT0_VALUE(ID_A), .IDENT1_VALUE(ID_B),
    .RESET_CODE(RCODE)) dut (
    .CLK_SYS(clk), .RESETN(resetn), .BUS(bus), .PRIM_TERMS(prim), .SEC_TERMS(sec),
    .SRAM_TERMS(sram), .IO_SEL(io), .FLASH_OP(op), .FLASH_LEFT_READ(left),
    .SEQ_TIMEOUT(tmo), .SEQ_BAD_BIT(bad), .RESET_PIN_N(pin_n), .WIDE_ADDR(wide),
    .POWER_DOWN_IN(power_down_input), .PORT_IN(port_pins), .MC_FB(mcfb), .CTRL_AUX(2'b11),
    .SEL_OUT(sel), .CFG_DOUT(cfg_dout), .PAGE_OUT(page), .READ_MODE(rmode),
    .ERROR_FLAG(eflag), .ABORT_SECTOR(abs), .ABORT_ALL(aba), .LA_BUS(la),
    .LA_AUX(la_aux), .LA_STANDBY(sb));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cw(input logic [7:0] o, input logic [7:0] d);
    h.acc({12'h000, o}, d, 4'h9);
  endtask
  task automatic cr(input logic [7:0] o);
    h.acc({12'h000, o}, 8'h00, 4'h5);
  endtask
  // Some cases drive two select levels at once to check which one wins
  task automatic sel_case(input logic [23:0] p, input logic [11:0] s, input logic [2:0] r,
    input logic i, input logic [3:0] st, input logic [13:0] e);
    prim <= p;
    sec <= s;
    sram <= r;
    io <= i;
    h.acc(20'h08000, 8'h00, st);
    check(sel, e);
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    stop_test;
  end
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    #1;
    check(page, 8'h00);
    cr(`OFS_SPACE_MAP);
    check(h.rdata, `SPACE_MAP_INIT);
    cw(`OFS_PAGE, 8'hA5);
    check(page, 8'hA5);
    edges(1);
    check(la[24:17], 8'hA5);
    cr(`OFS_PAGE);
    check(h.rdata, 8'hA5);
    cw(`OFS_IDENT0, 8'h00);
    cr(`OFS_IDENT0);
    check(h.rdata, ID_A);
    cr(`OFS_IDENT1);
    check(h.rdata, ID_B);
    cr(8'h10);
    check(h.rdata, 8'h00);
    resetn <= 1'b0;
    edges(2);
    check(la[62], 1'b1);
    resetn <= 1'b1;
    edges(1);
    check(page, 8'h00);
    cr(`OFS_SPACE_MAP);
    check(h.rdata, `SPACE_MAP_INIT);
    $display("registers done");
    sel_case(24'h000001, 12'h000, 3'h4, 1'b0, 4'h4, 14'h2000);
    sel_case(24'h000000, 12'h001, 3'h0, 1'b1, 4'h4, 14'h1000);
    sel_case(24'h000000, 12'h000, 3'h1, 1'b0, 4'h0, 14'h0000);
    sel_case(24'h000020, 12'h000, 3'h0, 1'b0, 4'h4, 14'h0000);
    sel_case(24'h000020, 12'h000, 3'h0, 1'b0, 4'h2, 14'h0002);
    sel_case(24'h000000, 12'h001, 3'h0, 1'b0, 4'h4, 14'h0100);
    cw(`OFS_SPACE_MAP, 8'h14);
    cr(`OFS_SPACE_MAP);
    check(h.rdata, 8'h14);
    sel_case(24'h000020, 12'h000, 3'h0, 1'b0, 4'h4, 14'h0002);
    cw(`OFS_SPACE_MAP, 8'h1E);
    sel_case(24'h000020, 12'h008, 3'h0, 1'b0, 4'h2, 14'h0200);
    $display("selects done");
    for (int w = 0; w < 2; w++) begin
      wide <= w[0];
      h.acc(20'hABCDE, 8'h00, 4'h4);
      check(la[81:66], w ? 16'hABCD : 16'hBCDE);
    end
    power_down_input <= 1'b1;
    port_pins <= 36'hF01234567;
    mcfb <= 16'h9C3E;
    edges(1);
    check({la[62:61], la[16:0]}, {2'b01, 16'h9C3E, 1'b0});
    check(la[56:25], 32'h01234567);
    check(la[60:57], 4'hF);
    for (int k = 0; k < 2; k++) begin
      cw(`OFS_PMODE2, k ? 8'h1A : 8'h00);
      h.acc(20'h00000, 8'h00, 4'h4);
      check({la[64], la_aux}, k ? 3'b000 : 3'b111);
    end
    cw(`OFS_PMODE0, 8'h00);
    edges(20);
    check(sb, 1'b1);
    cw(`OFS_PMODE0, 8'h08);
    edges(20);
    check(sb, 1'b0);
    $display("logic array bus done");
    prim <= '0;
    sec <= 12'h001;
    for (int k = 0; k < 2; k++) begin
      op <= k ? OP_BULK : OP_PROGRAM;
      h.flash_reset(20'h08000, RCODE, 1'b1);
      check({rmode, abs}, 2'b00);
      check(la[0], 1'b1);
    end
    op <= OP_NONE;
    h.flash_reset(20'h08000, RCODE, 1'b1);
    check(rmode, 1'b1);
    op <= OP_SECTOR;
    h.flash_reset(20'h08000, RCODE, 1'b0);
    op <= OP_NONE;
    check({rmode, abs}, 2'b01);
    edges(RC - 1);
    check(rmode, 1'b0);
    edges(1);
    check(rmode, 1'b1);
    tmo <= 1'b1;
    edges(1);
    tmo <= 1'b0;
    check(eflag, 1'b1);
    left <= 1'b1;
    edges(1);
    left <= 1'b0;
    // Flag raised, so the host resets the flash
    h.flash_reset(20'h08000, RCODE, 1'b0);
    check(rmode, 1'b0);
    edges(RC);
    check({rmode, eflag}, 2'b10);
    $display("flash reset command done");
    bad <= 1'b1;
    edges(1);
    bad <= 1'b0;
    check(eflag, 1'b1);
    h.pin_pulse(RC + 5);
    edges(RC + 10);
    check(n_abort, 1);
    check(rmode, 1'b1);
    $display("reset pin done");
    stop_test;
  end
endmodule
`default_nettype wire
